// >>> rtl/slm_pkg.sv
// Constants, types and register map of the link monitor and test block.
// Assumes a single 25 MHz system clock and a word-wide Avalon-MM master.
package slm_pkg;
	localparam int unsigned CLK_HZ        = 25000000;
	// Register byte offsets
	localparam logic [3:0]  REG_CTRL      = 4'h0;
	localparam logic [3:0]  REG_STATUS    = 4'h4;
	localparam logic [3:0]  REG_LOF_CNT   = 4'h8;
	localparam logic [3:0]  REG_DCM       = 4'hc;
	// Control field positions, control reset value and status error field
	localparam int          CTL_SWRST     = 0;
	localparam int          CTL_LOOP      = 1;
	localparam int          CTL_BIST_EN   = 3;
	localparam int          CTL_PAT       = 4;
	localparam int          CTL_RATE      = 6;
	localparam int          CTL_BOOST     = 8;
	localparam int          CTL_EMPH      = 10;
	localparam logic [11:0] CTL_RESET     = 12'h000;
	localparam int          STS_ERR       = 16;
	// Loop modes
	localparam logic [1:0]  LOOP_NORMAL   = 2'h0;
	localparam logic [1:0]  LOOP_LINE     = 2'h1;
	localparam logic [1:0]  LOOP_LOCAL    = 2'h2;
	localparam logic [1:0]  LOOP_SPECIAL  = 2'h3;
	// Self-test patterns and base line rate
	localparam logic [1:0]  PAT_CJPAT0    = 2'h0;
	localparam logic [1:0]  PAT_PRWS10    = 2'h1;
	localparam logic [1:0]  RATE_1G2288   = 2'h0;
	// Framing, monitor limits and test-port widths
	localparam logic [7:0]  K28_5         = 8'hbc;
	localparam int unsigned HF_SYMS       = 4096;
	localparam int unsigned LCV_LIMIT     = 16;
	localparam int unsigned GRACE_HF      = 2;
	localparam int unsigned TP_CFG_BITS   = 7;
	localparam int unsigned TP_RES_BITS   = 3;
	// Least self-test run before the result is read
	localparam int unsigned TP_RUN_MS     = 300;
	localparam int unsigned TP_RUN_CYC    = TP_RUN_MS * (CLK_HZ / 1000);
	localparam int unsigned LOF_CNT_W     = 16;
	localparam int unsigned BIST_ERR_W    = 10;

	typedef enum logic [1:0] {
		ST_INIT,
		ST_RUN,
		ST_GRACE,
		ST_HALT
	} slm_state_t;

	// Pins from outside the clock domain
	typedef struct packed {
		logic [1:0] loop_sel;
		logic       raw_code_width_select;
		logic       operating_role;
		logic       chip_reset_n;
		logic       rx_pll_lock;
		logic       tck;
		logic       tdi;
		logic       shift_en;
		logic       config_capture_instruction;
		logic       selftest_cmd;
	} slm_pins_t;

	// Decoded receive symbol
	typedef struct packed {
		logic       line_code_violation;
		logic       is_k;
		logic [7:0] data;
	} slm_sym_t;
endpackage

// >>> rtl/slm_link_monitor.sv
// Receive link monitor: signal-absent and frame-missing detection, loopback
// select, self-test control and test-port configuration capture.
// Assumes a decoder on sys_clk_i delivers one symbol per rx_sym_valid_i, and
// an external pattern checker reports lock and bit errors on the same clock.
// Operation
// - Signal-absent high at power-up, pin reset and software reset.
// - Flag clears after K28.5 then one clean hyperframe.
// - PLL lock loss does not set the flag; violation count decides.
// - Base-station role: sixteen or more violations per hyperframe set flag.
// - Base-station role: violation-free hyperframe clears the flag.
// - 8-bit mode: outputs static until flag first goes low.
// - After flag rises, keep sending; clean hyperframe resumes operation.
// - Violations through grace hyperframes tri-state outputs and reset.
// - 10-bit mode: detection off, flag held high.
// - Frame-missing counter readable; function off in 10-bit mode.
// - Delay calibration start blocked while frame-missing is high.
// - Loop pins: 00 register control, 01 line, 10 local, 11 special.
// - Loop mode switch forces receive resynchronisation.
// - Self-test patterns CJPAT lane 0, PRWS10; enabled by register.
// - Self-test reports seen, pass and a 10-bit error count.
// - Self-test off in line or special line loopback.
// - Test-port self-test: local loop if captured bit 0 set, else normal; outputs tri-stated, PRWS10.
// - Captured settings override registers; 00 means base rate, no boost.
// - Test-port self-test command after config applies captured settings.
// - Result shifts out started, done, fault.
// - Width select 1 is 10-bit pass-through, 0 is 8-bit decoded.
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
module slm_link_monitor #(
	parameter int unsigned HF_LEN   = slm_pkg::HF_SYMS,
	parameter int unsigned BIST_RUN = slm_pkg::TP_RUN_CYC
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	// Asynchronous pins
	input  wire slm_pkg::slm_pins_t pins_i,
	// Decoded receive stream
	input  wire logic              rx_sym_valid_i,
	input  wire slm_pkg::slm_sym_t rx_sym_i,
	// Pattern checker
	input  wire logic              bist_lock_i,
	input  wire logic              bist_bit_err_i,
	// Avalon-MM slave
	input  wire logic [3:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	// Receive outputs
	output logic [9:0]             rx_parallel_bus_o,
	output logic                   rx_word_clock_o,
	output logic                   rx_out_oe_n_o,
	output logic                   signal_absent_flag_o,
	output logic                   frame_missing_flag_o,
	// Link settings
	output logic [1:0]             loop_mode_o,
	output logic [1:0]             line_rate_select_o,
	output logic [1:0]             rx_boost_level_o,
	output logic [1:0]             tx_emphasis_level_o,
	// Self-test and calibration
	output logic                   bist_run_o,
	output logic [1:0]             bist_pattern_o,
	output logic                   dcm_start_o,
	output logic                   tp_tdo_o
);
	initial begin
		if (HF_LEN < 2 || HF_LEN > 65536 || BIST_RUN < 1 || BIST_RUN > 16777215)
			$error("slm_link_monitor: parameter out of range");
	end

	localparam logic [15:0] HF_LAST = 16'(HF_LEN - 1);
	localparam logic [23:0] RUN_LAST = 24'(BIST_RUN - 1);

	// Pin synchroniser, change accepted when stages two and three agree
	slm_pkg::slm_pins_t p1, p2, p3, pq;
	logic                tck_d;
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			p1    <= '0;
			p2    <= '0;
			p3    <= '0;
			pq    <= '0;
			tck_d <= 1'b0;
		end else begin
			p1    <= pins_i;
			p2    <= p1;
			p3    <= p2;
			pq    <= (p3 & ~(p2 ^ p3)) | (pq & (p2 ^ p3));
			tck_d <= pq.tck;
		end
	end
	wire tck_rise = pq.tck & ~tck_d;
	wire raw_w    = pq.raw_code_width_select;

	// Bus side state
	logic [11:0] ctl, next_ctl;
	logic        ack, next_ack;
	logic [31:0] rdata, next_rdata;
	logic        swrst, next_swrst;
	logic        delay_calibration_unit, next_dcm;
	// Link state
	slm_pkg::slm_state_t st, next_st;
	logic        signal_absent_flag, next_los;
	logic        synced, next_synced;
	logic [15:0] hf_cnt, next_hf_cnt;
	logic [4:0]  lcv_cnt, next_lcv_cnt;
	logic [1:0]  grace, next_grace;
	logic        frame_missing_flag, next_lof;
	logic [15:0] lof_cnt, next_lof_cnt;
	logic [1:0]  loop_q;
	// Test port state
	logic [6:0]  tcfg, next_tcfg;
	logic        tcfg_ok, next_tcfg_ok;
	logic        tp_mode, next_tp_mode;
	logic [2:0]  tres, next_tres;
	// Self-test state
	logic        seen, next_seen;
	logic        done, next_done;
	logic [9:0]  errs, next_errs;
	logic [23:0] run_cnt, next_run_cnt;

	// Internal reset: port, pin and software
	wire lrst = rst_i | ~pq.chip_reset_n | swrst;

	// Loop mode: pins win unless 00, test port forces local if tcfg[0] is set, else normal
	logic [1:0] loop_eff;
	always_comb begin
		loop_eff = (pq.loop_sel == slm_pkg::LOOP_NORMAL) ?
			ctl[slm_pkg::CTL_LOOP +: 2] : pq.loop_sel;
		if (tp_mode)
			loop_eff = tcfg[0] ? slm_pkg::LOOP_LOCAL : slm_pkg::LOOP_NORMAL;
	end
	wire loop_chg = loop_eff != loop_q;

	wire is_comma = rx_sym_valid_i & rx_sym_i.is_k & (rx_sym_i.data == slm_pkg::K28_5);
	wire hf_end   = rx_sym_valid_i & synced & (hf_cnt == HF_LAST);
	wire lcv_now  = rx_sym_valid_i & rx_sym_i.line_code_violation;
	// Counts including the symbol of the closing cycle
	wire [5:0] lcv_tot = {1'b0, lcv_cnt} + {5'h00, lcv_now};
	wire lcv_many = lcv_tot >= 6'(slm_pkg::LCV_LIMIT);
	wire lcv_none = lcv_tot == 6'h00;

	// Avalon slave, one wait state per access
	always_comb begin
		next_ack   = (avs_read | avs_write) & ~ack;
		next_rdata = rdata;
		next_ctl   = ctl;
		next_swrst = 1'b0;
		next_dcm   = 1'b0;
		if (avs_read & ~ack) begin
			case (avs_address)
				slm_pkg::REG_CTRL: next_rdata = {20'h00000, ctl};
				slm_pkg::REG_STATUS: next_rdata = {6'h00, errs, 6'h00, pq.rx_pll_lock, tp_mode,
					loop_eff, ~raw_w & ~frame_missing_flag, done, bist_run_o & seen & done & (errs == 10'h000),
					seen, frame_missing_flag, signal_absent_flag};
				slm_pkg::REG_LOF_CNT: next_rdata = {16'h0000, lof_cnt};
				default: next_rdata = 32'h00000000;
			endcase
		end
		if (avs_write & ack) begin
			case (avs_address)
				slm_pkg::REG_CTRL: begin
					next_ctl   = avs_writedata[11:0] & ~12'h001;
					next_swrst = avs_writedata[slm_pkg::CTL_SWRST];
				end
				slm_pkg::REG_DCM: next_dcm = avs_writedata[0] & ~raw_w & ~frame_missing_flag;
				default: next_ctl = ctl;
			endcase
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ack   <= 1'b0;
			rdata <= 32'h00000000;
			ctl   <= slm_pkg::CTL_RESET;
			swrst <= 1'b0;
			delay_calibration_unit   <= 1'b0;
		end else begin
			ack   <= next_ack;
			rdata <= next_rdata;
			ctl   <= next_ctl;
			swrst <= next_swrst;
			delay_calibration_unit   <= next_dcm;
		end
	end
	assign avs_waitrequest = (avs_read | avs_write) & ~ack;
	assign avs_readdata    = rdata;
	assign dcm_start_o     = delay_calibration_unit;

	// Link monitor: flag, hyperframe tracking, frame-missing
	always_comb begin
		next_st      = st;
		next_los     = signal_absent_flag;
		next_synced  = synced;
		next_hf_cnt  = hf_cnt;
		next_lcv_cnt = lcv_cnt;
		next_grace   = grace;
		next_lof     = frame_missing_flag;
		next_lof_cnt = lof_cnt;
		if (rx_sym_valid_i) begin
			if (!synced && is_comma) begin
				next_synced = 1'b1;
				next_hf_cnt = 16'h0001;
			end else if (synced) begin
				next_hf_cnt = hf_end ? 16'h0000 : hf_cnt + 16'h0001;
			end
			if (synced && hf_cnt == 16'h0000) begin
				next_lof = ~is_comma;
				if (!is_comma && !frame_missing_flag)
					next_lof_cnt = lof_cnt + 16'h0001;
			end
		end
		// Violations counted regardless of PLL lock
		if (hf_end)
			next_lcv_cnt = 5'h00;
		else if (lcv_now && !lcv_cnt[4])
			next_lcv_cnt = lcv_cnt + 5'h01;
		if (hf_end) begin
			case (st)
				slm_pkg::ST_INIT, slm_pkg::ST_HALT: begin
					if (lcv_none) begin
						next_st  = slm_pkg::ST_RUN;
						next_los = 1'b0;
					end
				end
				slm_pkg::ST_RUN: begin
					if (lcv_many) begin
						next_st    = slm_pkg::ST_GRACE;
						next_los   = 1'b1;
						next_grace = 2'h0;
					end
				end
				slm_pkg::ST_GRACE: begin
					if (lcv_none) begin
						next_st  = slm_pkg::ST_RUN;
						next_los = 1'b0;
					end else if (grace == 2'(slm_pkg::GRACE_HF - 1)) begin
						next_st     = slm_pkg::ST_HALT;
						next_synced = 1'b0;
					end else begin
						next_grace = grace + 2'h1;
					end
				end
				default: next_st = slm_pkg::ST_INIT;
			endcase
		end
		if (loop_chg) begin
			next_st     = slm_pkg::ST_INIT;
			next_los    = 1'b1;
			next_synced = 1'b0;
			next_lof    = 1'b0;
		end
		if (raw_w) begin
			next_st  = slm_pkg::ST_INIT;
			next_los = 1'b1;
			next_lof = 1'b0;
			next_lof_cnt = lof_cnt;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (lrst) begin
			st      <= slm_pkg::ST_INIT;
			signal_absent_flag     <= 1'b1;
			synced  <= 1'b0;
			hf_cnt  <= 16'h0000;
			lcv_cnt <= 5'h00;
			grace   <= 2'h0;
			frame_missing_flag     <= 1'b0;
			lof_cnt <= 16'h0000;
			loop_q  <= slm_pkg::LOOP_NORMAL;
		end else begin
			st      <= next_st;
			signal_absent_flag     <= next_los;
			synced  <= next_synced;
			hf_cnt  <= next_hf_cnt;
			lcv_cnt <= next_lcv_cnt;
			grace   <= next_grace;
			frame_missing_flag     <= next_lof;
			lof_cnt <= next_lof_cnt;
			loop_q  <= loop_eff;
		end
	end
	assign signal_absent_flag_o = signal_absent_flag;
	assign frame_missing_flag_o = frame_missing_flag;

	// Receive output stage
	wire drive  = raw_w | st == slm_pkg::ST_RUN | st == slm_pkg::ST_GRACE;
	logic [9:0] bus_q;
	logic       wclk_q;
	always_ff @(posedge sys_clk_i) begin
		if (lrst) begin
			bus_q  <= 10'h000;
			wclk_q <= 1'b0;
		end else if (drive && rx_sym_valid_i) begin
			bus_q  <= rx_sym_i;
			wclk_q <= ~wclk_q;
		end
	end
	assign rx_parallel_bus_o = bus_q;
	assign rx_word_clock_o   = wclk_q;
	assign rx_out_oe_n_o     = tp_mode | (~raw_w & st == slm_pkg::ST_HALT);

	// Test port: config capture, self-test command, result shift
	always_comb begin
		next_tcfg    = tcfg;
		next_tcfg_ok = tcfg_ok;
		next_tp_mode = tp_mode;
		next_tres    = tres;
		if (tck_rise && pq.shift_en) begin
			if (pq.config_capture_instruction) begin
				next_tcfg    = {pq.tdi, tcfg[6:1]};
				next_tcfg_ok = 1'b1;
			end else begin
				next_tres = {tres[1:0], 1'b0};
			end
		end else if (tck_rise && !pq.selftest_cmd) begin
			next_tres = {seen, done, errs != 10'h000};
		end
		if (tck_rise && pq.selftest_cmd && !pq.shift_en)
			next_tp_mode = 1'b1;
	end
	always_ff @(posedge sys_clk_i) begin
		if (lrst) begin
			tcfg    <= 7'h00;
			tcfg_ok <= 1'b0;
			tp_mode <= 1'b0;
			tres    <= 3'h0;
		end else begin
			tcfg    <= next_tcfg;
			tcfg_ok <= next_tcfg_ok;
			tp_mode <= next_tp_mode;
			tres    <= next_tres;
		end
	end
	assign tp_tdo_o = tres[2];

	// Captured settings, else registers
	always_comb begin
		loop_mode_o         = loop_eff;
		line_rate_select_o  = ctl[slm_pkg::CTL_RATE +: 2];
		rx_boost_level_o    = ctl[slm_pkg::CTL_BOOST +: 2];
		tx_emphasis_level_o = ctl[slm_pkg::CTL_EMPH +: 2];
		bist_pattern_o      = ctl[slm_pkg::CTL_PAT +: 2];
		if (tcfg_ok) begin
			line_rate_select_o  = {tcfg[1], tcfg[2]};
			rx_boost_level_o    = {tcfg[3], tcfg[4]};
			tx_emphasis_level_o = {tcfg[6], tcfg[5]};
		end else if (tp_mode) begin
			line_rate_select_o = slm_pkg::RATE_1G2288;
		end
		if (tp_mode)
			bist_pattern_o = slm_pkg::PAT_PRWS10;
	end

	// Self-test run, disabled in line loopbacks
	assign bist_run_o = (ctl[slm_pkg::CTL_BIST_EN] | tp_mode) &
		loop_eff != slm_pkg::LOOP_LINE & loop_eff != slm_pkg::LOOP_SPECIAL;
	always_comb begin
		next_seen    = seen;
		next_done    = done;
		next_errs    = errs;
		next_run_cnt = run_cnt;
		if (!bist_run_o) begin
			next_seen    = 1'b0;
			next_done    = 1'b0;
			next_errs    = 10'h000;
			next_run_cnt = 24'h000000;
		end else begin
			next_seen = seen | bist_lock_i;
			if (seen && bist_bit_err_i && errs != 10'h3ff)
				next_errs = errs + 10'h001;
			if (seen && run_cnt == RUN_LAST)
				next_done = 1'b1;
			else if (seen)
				next_run_cnt = run_cnt + 24'h000001;
		end
	end
	always_ff @(posedge sys_clk_i) begin
		if (lrst) begin
			seen    <= 1'b0;
			done    <= 1'b0;
			errs    <= 10'h000;
			run_cnt <= 24'h000000;
		end else begin
			seen    <= next_seen;
			done    <= next_done;
			errs    <= next_errs;
			run_cnt <= next_run_cnt;
		end
	end

	// Checks
	property p_rst_los;
		@(posedge sys_clk_i) rst_i |=> signal_absent_flag;
	endproperty
	a_rst_los: assert property (p_rst_los) else $error("flag low after reset");
	property p_los_fall;
		@(posedge sys_clk_i) disable iff (lrst)
		$fell(signal_absent_flag) |-> $past(hf_end) && $past(lcv_none);
	endproperty
	a_los_fall: assert property (p_los_fall) else $error("flag fell without clean frame");
	property p_los_rise;
		@(posedge sys_clk_i) disable iff (lrst)
		(st == slm_pkg::ST_RUN && hf_end && lcv_many && !loop_chg && !raw_w)
		|=> signal_absent_flag && st == slm_pkg::ST_GRACE;
	endproperty
	a_los_rise: assert property (p_los_rise) else $error("flag not set");
	property p_raw;
		@(posedge sys_clk_i) disable iff (lrst) raw_w |=> signal_absent_flag && !frame_missing_flag;
	endproperty
	a_raw: assert property (p_raw) else $error("10-bit mode flags wrong");
	property p_static;
		@(posedge sys_clk_i) disable iff (lrst)
		(!raw_w && st == slm_pkg::ST_INIT) |=> $stable(rx_parallel_bus_o);
	endproperty
	a_static: assert property (p_static) else $error("bus moved before lock");
	property p_halt;
		@(posedge sys_clk_i) disable iff (lrst)
		(st == slm_pkg::ST_GRACE && hf_end && !lcv_none && grace == 2'h1 && !loop_chg && !raw_w)
		|=> rx_out_oe_n_o;
	endproperty
	a_halt: assert property (p_halt) else $error("outputs not released");
	property p_dcm;
		@(posedge sys_clk_i) disable iff (lrst) dcm_start_o |-> $past(!frame_missing_flag && !raw_w);
	endproperty
	a_dcm: assert property (p_dcm) else $error("calibration started while frame missing");
	property p_bist_off;
		@(posedge sys_clk_i) disable iff (lrst)
		(loop_mode_o == slm_pkg::LOOP_LINE || loop_mode_o == slm_pkg::LOOP_SPECIAL) |-> !bist_run_o;
	endproperty
	a_bist_off: assert property (p_bist_off) else $error("self-test in line loop");
	property p_resync;
		@(posedge sys_clk_i) disable iff (lrst) loop_chg |=> !synced && signal_absent_flag;
	endproperty
	a_resync: assert property (p_resync) else $error("no resync on loop change");
	property p_tp;
		@(posedge sys_clk_i) disable iff (lrst)
		tp_mode |-> rx_out_oe_n_o && bist_pattern_o == slm_pkg::PAT_PRWS10;
	endproperty
	a_tp: assert property (p_tp) else $error("test-port self-test setup wrong");
endmodule

// >>> test/slm_far_end.sv
// Far-end model: remote transceiver sending a framed, decoded symbol stream.
// Assumes one symbol every second clock and HF_LEN symbols per hyperframe.
module slm_far_end #(
	parameter int HF_LEN = 32
) (
	// Clock and reset
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	// Controls from the bench
	input  wire logic              en_i,
	input  wire logic [5:0]        n_lcv_i,
	input  wire logic              bad_k_i,
	// Symbol stream
	output logic                   sym_valid_o,
	output slm_pkg::slm_sym_t      sym_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] idx;
	logic [5:0] n_cur;
	logic [5:0] n_use;

	// Violation count is fixed for a whole frame at its first symbol
	assign n_use = (idx == 6'h00) ? n_lcv_i : n_cur;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !en_i || sym_valid_o) begin
			// Idle line: data pattern changes every cycle
			sym_valid_o <= 1'b0;
			sym_o       <= ~sym_o;
			if (rst_i || !en_i) begin
				idx <= 6'h00;
			end
		end else begin
			sym_valid_o <= 1'b1;
			n_cur       <= n_use;
			sym_o.line_code_violation   <= (idx != 6'h00) && (idx <= n_use);
			sym_o.is_k  <= (idx == 6'h00) && !bad_k_i;
			sym_o.data  <= (idx != 6'h00) ? {2'h0, idx} : (bad_k_i ? 8'h3c : slm_pkg::K28_5);
			idx         <= (idx == 6'(HF_LEN - 1)) ? 6'h00 : idx + 6'h01;
		end
	end
endmodule

// >>> test/slm_link_monitor_tb.sv
// Self-checking bench: register bus, pins, symbol stream and test port.
// Assumes the far-end model slm_far_end and a 25 MHz clock.
`define CHK(nm, e, g) \
	begin \
		compares++; \
		if ((g) !== (e)) begin \
			n_errors++; \
			$display("[ERR] %s expected %0h seen %0h", nm, e, g); \
		end \
	end

module slm_link_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HF = 32;
	logic               sys_clk_i, rst_i, en, bad_k, bist_lock, bist_err, sym_valid;
	logic               avs_read, avs_write, avs_waitrequest, wclk, oe_n, flag, frame_missing_flag;
	logic               bist_run, delay_calibration_unit, tdo;
	logic [1:0]         loop_mode, rate, boost, emph, pattern;
	logic [3:0]         avs_address;
	logic [5:0]         n_lcv;
	logic [9:0]         rx_bus;
	logic [31:0]        avs_writedata, avs_readdata, q;
	logic [2:0]         r;
	slm_pkg::slm_pins_t pins;
	slm_pkg::slm_sym_t  sym;
	int                 n_errors = 0, compares = 0, cyc = 0, n_dcm = 0, k;

	slm_far_end #(.HF_LEN(HF)) FAR (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .en_i(en),
		.n_lcv_i(n_lcv), .bad_k_i(bad_k), .sym_valid_o(sym_valid), .sym_o(sym));

	slm_link_monitor #(.HF_LEN(HF), .BIST_RUN(20)) DUT (.sys_clk_i(sys_clk_i),
		.rst_i(rst_i), .pins_i(pins), .rx_sym_valid_i(sym_valid), .rx_sym_i(sym),
		.bist_lock_i(bist_lock), .bist_bit_err_i(bist_err), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.rx_parallel_bus_o(rx_bus), .rx_word_clock_o(wclk), .rx_out_oe_n_o(oe_n),
		.signal_absent_flag_o(flag), .frame_missing_flag_o(frame_missing_flag), .loop_mode_o(loop_mode),
		.line_rate_select_o(rate), .rx_boost_level_o(boost), .tx_emphasis_level_o(emph),
		.bist_run_o(bist_run), .bist_pattern_o(pattern), .dcm_start_o(delay_calibration_unit), .tp_tdo_o(tdo));

	task automatic stop_test();
		$display("Comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic look(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// Holds the request until waitrequest is seen low at a rising edge
	task automatic bus(input int wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] rd);
		@(posedge sys_clk_i);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= (wr != 0);
		avs_read      <= (wr == 0);
		// Values read here are those sampled at this rising edge
		do @(posedge sys_clk_i); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
	endtask

	task automatic wait_until(input int w, input logic v, input int lim);
		int   n;
		logic s;
		n = 0;
		s = ~v;
		while (s !== v && n < lim) begin
			@(negedge sys_clk_i);
			n++;
			s = (w == 0) ? flag : (w == 1) ? oe_n : frame_missing_flag;
		end
	endtask

	task automatic tck_pulse();
		@(posedge sys_clk_i) pins.tck <= 1'b1;
		repeat (8) @(posedge sys_clk_i);
		pins.tck <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
	endtask

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		if (delay_calibration_unit === 1'b1) n_dcm <= n_dcm + 1;
		if (cyc == 20000) begin
			n_errors++;
			$display("[ERR] run length expected finish seen hang");
			stop_test();
		end
	end

	initial begin
		rst_i = 1'b1;
		pins = '0;
		pins.chip_reset_n = 1'b1;
		pins.rx_pll_lock = 1'b1;
		{en, bad_k, bist_lock, bist_err, avs_read, avs_write} = '0;
		{n_lcv, avs_address, avs_writedata} = '0;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		look(8);
		`CHK("flag", 1'b1, flag)
		bus(0, slm_pkg::REG_CTRL, 0, q);
		`CHK("ctrl", 32'h0, q)
		bus(1, 4'h1, 32'hffffffff, q);
		bus(0, 4'h1, 0, q);
		`CHK("unmapped", 32'h0, q)
		@(posedge sys_clk_i) en <= 1'b1;
		look(20);
		`CHK("wclk", 1'b0, wclk)
		`CHK("rx_bus", 10'h0, rx_bus)
		wait_until(0, 1'b0, 400);
		`CHK("flag", 1'b0, flag)
		`CHK("oe_n", 1'b0, oe_n)
		r[0] = wclk;
		look(2);
		`CHK("wclk toggle", ~r[0], wclk)
		@(posedge sys_clk_i) pins.rx_pll_lock <= 1'b0;
		look(200);
		`CHK("flag", 1'b0, flag)
		@(posedge sys_clk_i) pins.rx_pll_lock <= 1'b1;
		n_lcv <= 6'd15;
		look(64);
		@(posedge sys_clk_i) n_lcv <= 6'd0;
		look(130);
		`CHK("flag", 1'b0, flag)
		@(posedge sys_clk_i) n_lcv <= 6'd16;
		wait_until(0, 1'b1, 200);
		`CHK("flag", 1'b1, flag)
		`CHK("oe_n", 1'b0, oe_n)
		r[0] = wclk;
		look(2);
		`CHK("wclk toggle", ~r[0], wclk)
		@(posedge sys_clk_i) n_lcv <= 6'd0;
		wait_until(0, 1'b0, 200);
		`CHK("flag", 1'b0, flag)
		@(posedge sys_clk_i) n_lcv <= 6'd16;
		wait_until(1, 1'b1, 600);
		`CHK("oe_n", 1'b1, oe_n)
		`CHK("flag", 1'b1, flag)
		@(posedge sys_clk_i) n_lcv <= 6'd0;
		wait_until(0, 1'b0, 400);
		`CHK("oe_n", 1'b0, oe_n)
		bus(1, slm_pkg::REG_CTRL, 32'h1, q);
		wait_until(0, 1'b1, 10);
		`CHK("flag", 1'b1, flag)
		wait_until(0, 1'b0, 400);
		k = n_dcm;
		bus(1, slm_pkg::REG_DCM, 32'h1, q);
		look(4);
		`CHK("dcm pulses", k + 1, n_dcm)
		@(posedge sys_clk_i) bad_k <= 1'b1;
		wait_until(2, 1'b1, 200);
		`CHK("lof", 1'b1, frame_missing_flag)
		@(posedge sys_clk_i) bad_k <= 1'b0;
		k = n_dcm;
		bus(1, slm_pkg::REG_DCM, 32'h1, q);
		look(4);
		`CHK("dcm pulses", k, n_dcm)
		bus(0, slm_pkg::REG_LOF_CNT, 0, q);
		`CHK("lof count", 32'h1, q)
		for (int m = 1; m < 4; m++) begin
			@(posedge sys_clk_i) pins.loop_sel <= 2'(m);
			look(8);
			`CHK("loop_mode", 2'(m), loop_mode)
		end
		@(posedge sys_clk_i) pins.loop_sel <= slm_pkg::LOOP_NORMAL;
		bist_lock <= 1'b1;
		look(8);
		// Register loop local, self-test on, pattern PRWS10
		bus(1, slm_pkg::REG_CTRL, 32'h1c, q);
		look(2);
		`CHK("loop_mode", slm_pkg::LOOP_LOCAL, loop_mode)
		`CHK("flag", 1'b1, flag)
		`CHK("bist_run", 1'b1, bist_run)
		`CHK("pattern", slm_pkg::PAT_PRWS10, pattern)
		bus(0, slm_pkg::REG_CTRL, 0, q);
		`CHK("ctrl", 32'h1c, q)
		repeat (3) begin
			@(posedge sys_clk_i) bist_err <= 1'b1;
			@(posedge sys_clk_i) bist_err <= 1'b0;
		end
		bus(0, slm_pkg::REG_STATUS, 0, q);
		`CHK("err count", 10'h3, q[25:16])
		`CHK("seen", 1'b1, q[2])
		bus(1, slm_pkg::REG_CTRL, 32'h0c, q);
		look(2);
		`CHK("pattern", slm_pkg::PAT_CJPAT0, pattern)
		for (int m = 1; m < 4; m += 2) begin
			@(posedge sys_clk_i) pins.loop_sel <= 2'(m);
			look(8);
			`CHK("bist_run", 1'b0, bist_run)
		end
		@(posedge sys_clk_i) pins.loop_sel <= slm_pkg::LOOP_NORMAL;
		pins.raw_code_width_select <= 1'b1;
		look(200);
		`CHK("flag", 1'b1, flag)
		bus(0, slm_pkg::REG_STATUS, 0, q);
		`CHK("lof", 1'b0, q[1])
		@(posedge sys_clk_i) pins.raw_code_width_select <= 1'b0;
		pins.chip_reset_n <= 1'b0;
		look(200);
		`CHK("flag", 1'b1, flag)
		@(posedge sys_clk_i) pins.chip_reset_n <= 1'b1;
		rst_i <= 1'b1;
		@(posedge sys_clk_i) rst_i <= 1'b0;
		look(10);
		// Near-loop 1, rate 10, boost 01, emphasis 10, near-loop shifted first
		@(posedge sys_clk_i) pins.shift_en <= 1'b1;
		pins.config_capture_instruction <= 1'b1;
		for (int i = 6; i >= 0; i--) begin
			@(posedge sys_clk_i) pins.tdi <= 1'(7'b1100101 >> i);
			tck_pulse();
		end
		@(posedge sys_clk_i) pins.shift_en <= 1'b0;
		pins.config_capture_instruction <= 1'b0;
		pins.selftest_cmd <= 1'b1;
		tck_pulse();
		look(8);
		`CHK("loop_mode", slm_pkg::LOOP_LOCAL, loop_mode)
		`CHK("oe_n", 1'b1, oe_n)
		`CHK("pattern", slm_pkg::PAT_PRWS10, pattern)
		`CHK("bist_run", 1'b1, bist_run)
		bus(1, slm_pkg::REG_CTRL, 32'hfc0, q);
		look(4);
		`CHK("rate", 2'b10, rate)
		`CHK("boost", 2'b01, boost)
		`CHK("emph", 2'b10, emph)
		look(100);
		@(posedge sys_clk_i) pins.selftest_cmd <= 1'b0;
		tck_pulse();
		@(posedge sys_clk_i) pins.shift_en <= 1'b1;
		for (int i = 2; i >= 0; i--) begin
			look(2);
			r[i] = tdo;
			tck_pulse();
		end
		`CHK("result", 3'b110, r)
		stop_test();
	end
endmodule
